// ===== dv/neutral_oc_checker_assertions.sv
`timescale 1ns/1ps
module neutral_oc_checker
  import neutral_oc_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 meas_valid,
  input wire logic                 toc_block,
  input wire logic                 ioc_block,
  input reset_mode_type            toc_reset_mode,
  input wire logic [TIMER_W-1:0]   ioc_delay,
  input wire logic                 residual_time_overcurrent_pkp,
  input wire logic                 residual_time_overcurrent_op,
  input wire logic                 residual_instant_overcurrent_pkp,
  input wire logic                 residual_instant_overcurrent_op,
  input wire logic [DIR_COUNT-1:0] forward_direction_operand,
  input wire logic [DIR_COUNT-1:0] reverse_direction_operand
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Time element pickup moves only at an edge that takes a strobe.
  property p_toc_stands;
    !meas_valid |=> $stable(residual_time_overcurrent_pkp);
  endproperty
  a_toc_stands: assert property (p_toc_stands)
    else $error("time pickup moved without a strobe");
  property p_toc_block;
    meas_valid && toc_block |=> !residual_time_overcurrent_pkp;
  endproperty
  a_toc_block: assert property (p_toc_block)
    else $error("blocked time element still picked up");
  // Instantaneous reset must drop operate on the blocked strobe itself.
  property p_toc_inst;
    meas_valid && toc_block && toc_reset_mode == RESET_INSTANT
      |=> !residual_time_overcurrent_op;
  endproperty
  a_toc_inst: assert property (p_toc_inst)
    else $error("blocked time element kept operate");
  property p_ioc_block;
    meas_valid && ioc_block |=> !residual_instant_overcurrent_pkp
      && !residual_instant_overcurrent_op;
  endproperty
  a_ioc_block: assert property (p_ioc_block)
    else $error("blocked instant element active");
  // With no intentional delay operate follows pickup at once.
  property p_ioc_nodelay;
    meas_valid && !ioc_block && ioc_delay == '0 |=>
      residual_instant_overcurrent_op == residual_instant_overcurrent_pkp;
  endproperty
  a_ioc_nodelay: assert property (p_ioc_nodelay)
    else $error("instant operate lagged pickup");
  property p_ioc_op_pkp;
    residual_instant_overcurrent_op |-> residual_instant_overcurrent_pkp;
  endproperty
  a_ioc_op_pkp: assert property (p_ioc_op_pkp)
    else $error("instant operate without pickup");
  // Reverse operands change only two edges after a strobe.
  property p_rev_stands;
    !$stable(reverse_direction_operand) |-> $past(meas_valid, 2);
  endproperty
  a_rev_stands: assert property (p_rev_stands)
    else $error("reverse operand moved off strobe timing");
  property p_dir_excl;
    (forward_direction_operand & reverse_direction_operand) == '0;
  endproperty
  a_dir_excl: assert property (p_dir_excl)
    else $error("forward and reverse asserted together");
  c_fwd: cover property ($rose(forward_direction_operand[0]));
  c_rev: cover property ($rose(reverse_direction_operand[0]));
  c_toc: cover property ($rose(residual_time_overcurrent_op));
endmodule

// ===== dv/neutral_overcurrent_protection_test.sv
`timescale 1ns/1ps
module neutral_overcurrent_protection_test;
  import neutral_oc_pkg::*;
  // Short reversal counts keep the run brief.
  localparam int PERSIST = 20;
  localparam int HOLDOFF = 30;
  typedef struct packed {
    logic src;
    logic [15:0] i0, rms, i1;
    logic ioc, toc;
  } row_type;
  // Source, I0, RMS, I1, then expected instant and time pickup.
  row_type rows [6] = '{
    '{1'h0, 16'h03E9, 16'h0000, 16'h0000, 1'h1, 1'h1},
    '{1'h0, 16'h03E9, 16'h0000, 16'h0020, 1'h0, 1'h1},
    '{1'h0, 16'h044B, 16'h0000, 16'h0640, 1'h0, 1'h1},
    '{1'h0, 16'h03E7, 16'h0000, 16'h0000, 1'h0, 1'h0},
    '{1'h1, 16'h0000, 16'h03E9, 16'h0000, 1'h0, 1'h1},
    '{1'h0, 16'h000A, 16'h0000, 16'h1000, 1'h0, 1'h0}};
  reset_mode_type modes [2] = '{RESET_INSTANT, RESET_TIMED};
  logic ref_clk, rst_n, meas_valid, toc_block, ioc_block;
  logic [MAG_W-1:0] i0_mag, i0_rms, i1_mag, ig_mag, v0_mag, vx_mag;
  logic signed [MAG_W-1:0] i0_re, i0_im, ig_re, ig_im;
  logic signed [MAG_W-1:0] v0_re, v0_im, vx_re, vx_im;
  toc_source_type toc_source;
  reset_mode_type toc_reset_mode;
  logic [OP_W-1:0] toc_pickup_level, ioc_pickup_level;
  logic [TIMER_W-1:0] toc_delay, ioc_delay;
  op_source_type dir_op_source [DIR_COUNT];
  pol_mode_type dir_pol_mode [DIR_COUNT];
  vsel_type polarizing_voltage_select [DIR_COUNT];
  logic [K_W-1:0] dir_restraint_k [DIR_COUNT];
  logic [MAG_W-1:0] dir_offset_z [DIR_COUNT];
  logic signed [ROT_W-1:0] characteristic_angle_cos [DIR_COUNT];
  logic signed [ROT_W-1:0] characteristic_angle_sin [DIR_COUNT];
  logic [LIM_W-1:0] forward_limit_cos [DIR_COUNT];
  logic [LIM_W-1:0] reverse_limit_cos [DIR_COUNT];
  logic [OP_W-1:0] dir_fwd_pickup [DIR_COUNT], dir_rev_pickup [DIR_COUNT];
  logic residual_time_overcurrent_pkp, residual_time_overcurrent_op;
  logic residual_instant_overcurrent_pkp, residual_instant_overcurrent_op;
  logic [DIR_COUNT-1:0] forward_direction_operand, reverse_direction_operand;
  wire [1:0] ioc_pair = {residual_instant_overcurrent_pkp,
    residual_instant_overcurrent_op};
  wire [1:0] toc_pair = {residual_time_overcurrent_pkp,
    residual_time_overcurrent_op};
  int errors, num_checks;
  phasor_source i_src (.ref_clk, .meas_valid);
  neutral_overcurrent_protection #(.REV_PERSIST_CYCLES(PERSIST),
    .FWD_DELAY_CYCLES(HOLDOFF)) i_dut (.*);
  task automatic check(input string what, input logic [3:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One strobe, then n more falling edges before looking.
  task automatic step(input int n);
    i_src.send();
    repeat (n) @(negedge ref_clk);
  endtask
  // Directional operands settle two edges after the strobe.
  task automatic dir(input string what, input logic [1:0] fwd, rev);
    step(1);
    check(what, forward_direction_operand, fwd);
    check(what, reverse_direction_operand, rev);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // A hang counts as a failure.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim();
  end
  initial
  begin
    {errors, num_checks, rst_n, toc_block, ioc_block} = '0;
    {i0_mag, i0_rms, i1_mag, vx_mag} = '0;
    {ig_mag, v0_mag} = {16'h03E8, 16'h07D0};
    {i0_im, ig_im, v0_im, vx_im, vx_re} = '0;
    {i0_re, ig_re, v0_re} = {16'sh04B0, 16'sh03E8, -16'sh07D0};
    toc_source = TOC_PHASOR;
    toc_reset_mode = RESET_INSTANT;
    {toc_pickup_level, ioc_pickup_level} = {2{18'h00BB8}};
    {toc_delay, ioc_delay} = '0;
    foreach (dir_pol_mode[n])
    begin
      dir_op_source[n] = OP_CALCULATED;
      dir_pol_mode[n] = n ? POL_CURRENT : POL_VOLTAGE;
      polarizing_voltage_select[n] = VSEL_DERIVED;
      {dir_restraint_k[n], dir_offset_z[n]} = '0;
      {characteristic_angle_cos[n], characteristic_angle_sin[n]} = 32'h40000000;
      {forward_limit_cos[n], reverse_limit_cos[n]} = {2{15'h2000}};
      {dir_fwd_pickup[n], dir_rev_pickup[n]} = {2{18'h00BB8}};
    end
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    foreach (rows[r])
    begin
      toc_source = toc_source_type'(rows[r].src);
      {i0_mag, i0_rms, i1_mag} = {rows[r].i0, rows[r].rms, rows[r].i1};
      step(0);
      check("instant", ioc_pair, {2{rows[r].ioc}});
      check("time", toc_pair, {2{rows[r].toc}});
    end
    $display("rows done");
    {toc_source, i1_mag, toc_delay, ioc_delay} = {1'h0, 16'h0, 32'h00020001};
    foreach (modes[j])
    begin
      {i0_mag, toc_reset_mode, toc_block, ioc_block} = {16'h0, 3'h7};
      step(0);
      {toc_reset_mode, toc_block, ioc_block, i0_mag} = {modes[j], 18'h03E9};
      step(0);
      check("ioc delay", residual_instant_overcurrent_op, 4'h0);
      step(0);
      check("ioc delay", residual_instant_overcurrent_op, 4'h1);
      check("toc early", residual_time_overcurrent_op, 4'h0);
      step(0);
      check("toc due", residual_time_overcurrent_op, 4'h1);
      i0_mag = 16'h0000;
      step(0);
      i0_mag = 16'h03E9;
      step(0);
      step(0);
      check("toc reset", toc_pair[0], 4'(modes[j] == RESET_TIMED));
    end
    $display("timer done");
    i0_mag = 16'h04B0;
    dir("fwd", 2'h3, 2'h0);
    {dir_pol_mode[1], ig_re} = {POL_DUAL, -16'sh03E8};
    dir("dual", 2'h3, 2'h0);
    {dir_pol_mode[1], ig_re} = {POL_CURRENT, 16'sh03E8};
    dir_fwd_pickup[0] = 18'h00E10;
    dir("pickup", 2'h2, 2'h0);
    {dir_fwd_pickup[0], dir_restraint_k[0], i1_mag} = {18'hBB8, 32'h10000CCC};
    dir("k off", 2'h3, 2'h0);
    i1_mag = 16'h0CCD;
    dir("k on", 2'h2, 2'h0);
    {i1_mag, v0_mag} = {16'h0000, 16'h0051};
    dir("v weak", 2'h2, 2'h0);
    {polarizing_voltage_select[0], vx_re, vx_mag} = {1'h1, -16'sh1770, 16'h1770};
    dir("aux", 2'h3, 2'h0);
    vx_mag = 16'h00F3;
    dir("aux weak", 2'h2, 2'h0);
    polarizing_voltage_select[0] = VSEL_DERIVED;
    {v0_re, v0_mag, dir_offset_z[0]} = {16'sh0064, 16'h0064, 16'h0100};
    dir("offset", 2'h3, 2'h0);
    {dir_op_source[0], dir_fwd_pickup[0]} = {1'h1, 18'h003E8};
    dir("ground", 2'h2, 2'h0);
    {dir_op_source[0], dir_fwd_pickup[0]} = {1'h0, 18'h00BB8};
    {v0_re, v0_mag, dir_offset_z[0]} = {-16'sh07D0, 16'h07D0, 16'h0000};
    characteristic_angle_cos[0] = 16'sh0000;
    characteristic_angle_sin[0] = 16'sh4000;
    dir("eca", 2'h2, 2'h0);
    {characteristic_angle_cos[0], characteristic_angle_sin[0]} = 32'h40000000;
    i0_re = -16'sh04B0;
    dir("rev", 2'h0, 2'h3);
    repeat (25) @(negedge ref_clk);
    i0_re = 16'sh04B0;
    dir("guard", 2'h0, 2'h0);
    repeat (40) @(negedge ref_clk);
    dir("clear", 2'h3, 2'h0);
    $display("dir done");
    rst_n = 1'b0;
    @(negedge ref_clk);
    check("reset", {forward_direction_operand, toc_pair[0], ioc_pair[1]}, 4'h0);
    rst_n = 1'b1;
    $display("reset done");
    end_sim();
  end
endmodule
bind neutral_overcurrent_protection neutral_oc_checker i_chk (.*);

// ===== dv/phasor_source.sv
`timescale 1ns/1ps
// Upstream measurement stage that announces each new set with a strobe.
module phasor_source
(
  input  wire logic ref_clk,
  output logic      meas_valid
);
  initial meas_valid = 1'b0;
  // Driven at falling edges so rising edges see it settled.
  task automatic send();
    @(negedge ref_clk);
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
  endtask
endmodule

// ===== src/neutral_oc_pkg.sv
package neutral_oc_pkg;

  // Magnitudes are unsigned, phasor parts signed; one pu is PU_ONE counts.
  localparam int MAG_W   = 16;
  localparam int OP_W    = 18;
  localparam int AX_W    = 20;
  localparam int ROT_W   = 16;
  localparam int ROT_FRAC = 14;
  localparam int LIM_W   = 15;
  localparam int K_W     = 16;
  localparam int K_FRAC  = 12;
  localparam int Z_FRAC  = 8;
  localparam int SQ_W    = 128;
  localparam int TIMER_W = 16;
  localparam int TCNT_W  = 24;
  localparam int DIR_COUNT = 2;
  localparam int PU_ONE  = 4096;

  // Residual current is three times the zero-sequence current.
  localparam int RESIDUAL_GAIN = 3;
  localparam logic [OP_W-1:0] GAIN_OP = OP_W'(RESIDUAL_GAIN);
  localparam logic signed [MAG_W-1:0] DIV_S = MAG_W'(RESIDUAL_GAIN);
  localparam logic [MAG_W-1:0] DIV_U = MAG_W'(RESIDUAL_GAIN);

  // Fixed restraint of the instantaneous element, K = 1/16.
  localparam int IOC_K_SHIFT = 4;

  // Level thresholds, derived from per-unit figures.
  localparam logic [MAG_W-1:0] I1_RESTRAIN_MIN = MAG_W'(PU_ONE * 8 / 10);
  localparam logic [MAG_W-1:0] VPOL_MIN = MAG_W'(PU_ONE * 2 / 100);
  localparam logic [MAG_W-1:0] IPOL_MIN = MAG_W'(PU_ONE * 5 / 100);

  // Rotation by zero degrees in Q14, used by current polarizing.
  localparam logic signed [ROT_W-1:0] ROT_UNITY = 16'sh4000;
  localparam logic signed [ROT_W-1:0] ROT_NONE  = 16'sh0000;

  // Current reversal timing, in hundredths of a power cycle.
  localparam longint CLK_HZ   = 200_000_000;
  localparam longint POWER_HZ = 60;
  localparam longint CENTI    = 100;
  localparam longint REV_PERSIST_CENTI = 125;
  localparam longint FWD_DELAY_CENTI   = 150;
  localparam int REV_PERSIST_CYC = int'((CLK_HZ * REV_PERSIST_CENTI
    + CENTI * POWER_HZ - 1) / (CENTI * POWER_HZ));
  localparam int FWD_DELAY_CYC = int'((CLK_HZ * FWD_DELAY_CENTI
    + CENTI * POWER_HZ - 1) / (CENTI * POWER_HZ));

  typedef enum logic [2:0] {
    POL_VOLTAGE = 3'h1,
    POL_CURRENT = 3'h2,
    POL_DUAL    = 3'h4
  } pol_mode_type;

  typedef enum logic {OP_CALCULATED = 1'h0, OP_MEASURED = 1'h1}
    op_source_type;
  typedef enum logic {VSEL_DERIVED = 1'h0, VSEL_AUX = 1'h1} vsel_type;
  typedef enum logic {RESET_TIMED = 1'h0, RESET_INSTANT = 1'h1}
    reset_mode_type;
  typedef enum logic {TOC_PHASOR = 1'h0, TOC_RMS = 1'h1} toc_source_type;

  typedef enum logic [2:0] {
    REV_IDLE  = 3'h1,
    REV_ARMED = 3'h2,
    REV_HOLD  = 3'h4
  } reversal_type;

endpackage

// ===== src/neutral_overcurrent_protection.sv
`timescale 1ns/1ps
module neutral_overcurrent_protection
  import neutral_oc_pkg::*;
#(
  parameter int REV_PERSIST_CYCLES = REV_PERSIST_CYC,
  parameter int FWD_DELAY_CYCLES   = FWD_DELAY_CYC
)
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     meas_valid,
  input  wire logic        [MAG_W-1:0]  i0_mag,
  input  wire logic        [MAG_W-1:0]  i0_rms,
  input  wire logic        [MAG_W-1:0]  i1_mag,
  input  wire logic        [MAG_W-1:0]  ig_mag,
  input  wire logic        [MAG_W-1:0]  v0_mag,
  input  wire logic        [MAG_W-1:0]  vx_mag,
  input  wire logic signed [MAG_W-1:0]  i0_re,
  input  wire logic signed [MAG_W-1:0]  i0_im,
  input  wire logic signed [MAG_W-1:0]  ig_re,
  input  wire logic signed [MAG_W-1:0]  ig_im,
  input  wire logic signed [MAG_W-1:0]  v0_re,
  input  wire logic signed [MAG_W-1:0]  v0_im,
  input  wire logic signed [MAG_W-1:0]  vx_re,
  input  wire logic signed [MAG_W-1:0]  vx_im,
  input  toc_source_type                toc_source,
  input  reset_mode_type                toc_reset_mode,
  input  wire logic        [OP_W-1:0]   toc_pickup_level,
  input  wire logic        [TIMER_W-1:0] toc_delay,
  input  wire logic                     toc_block,
  input  wire logic        [OP_W-1:0]   ioc_pickup_level,
  input  wire logic        [TIMER_W-1:0] ioc_delay,
  input  wire logic                     ioc_block,
  input  op_source_type                 dir_op_source [DIR_COUNT],
  input  pol_mode_type                  dir_pol_mode [DIR_COUNT],
  input  vsel_type          polarizing_voltage_select [DIR_COUNT],
  input  wire logic        [K_W-1:0]    dir_restraint_k [DIR_COUNT],
  input  wire logic        [MAG_W-1:0]  dir_offset_z [DIR_COUNT],
  input  wire logic signed [ROT_W-1:0]
                            characteristic_angle_cos [DIR_COUNT],
  input  wire logic signed [ROT_W-1:0]
                            characteristic_angle_sin [DIR_COUNT],
  input  wire logic        [LIM_W-1:0]  forward_limit_cos [DIR_COUNT],
  input  wire logic        [LIM_W-1:0]  reverse_limit_cos [DIR_COUNT],
  input  wire logic        [OP_W-1:0]   dir_fwd_pickup [DIR_COUNT],
  input  wire logic        [OP_W-1:0]   dir_rev_pickup [DIR_COUNT],
  output logic                          residual_time_overcurrent_pkp,
  output logic                          residual_time_overcurrent_op,
  output logic                          residual_instant_overcurrent_pkp,
  output logic                          residual_instant_overcurrent_op,
  output wire logic [DIR_COUNT-1:0]     forward_direction_operand,
  output wire logic [DIR_COUNT-1:0]     reverse_direction_operand
);

  // Time overcurrent operating quantity and its pickup comparison.
  logic [MAG_W-1:0] toc_mag;
  logic [OP_W-1:0]  toc_iop;
  logic             toc_above;

  // Instantaneous element operating quantity with fixed restraint.
  logic [MAG_W-1:0] ioc_restr;
  logic [MAG_W-1:0] ioc_diff;
  logic [OP_W-1:0]  ioc_iop;
  logic             ioc_above;

  // The time element sees the unrestrained residual current.
  always_comb
  begin
    if (toc_source == TOC_RMS)
      toc_mag = i0_rms;
    else
      toc_mag = i0_mag;
    toc_iop   = OP_W'(toc_mag) * GAIN_OP;
    toc_above = toc_iop > toc_pickup_level;
  end

  // The difference is clamped at zero so a large I1 cannot wrap the result.
  always_comb
  begin
    ioc_restr = i1_mag >> IOC_K_SHIFT;
    if (i0_mag > ioc_restr)
      ioc_diff = i0_mag - ioc_restr;
    else
      ioc_diff = '0;
    ioc_iop   = OP_W'(ioc_diff) * GAIN_OP;
    ioc_above = ioc_iop > ioc_pickup_level;
  end

  // Time element: accumulator with selectable reset behaviour.
  pickup_timer u_toc (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .strobe     (meas_valid),
    .above      (toc_above),
    .block      (toc_block),
    .reset_mode (toc_reset_mode),
    .delay      (toc_delay),
    .pickup     (residual_time_overcurrent_pkp),
    .operate    (residual_time_overcurrent_op)
  );

  // Instantaneous element: a zero delay gives no intentional delay.
  pickup_timer u_ioc (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .strobe     (meas_valid),
    .above      (ioc_above),
    .block      (ioc_block),
    .reset_mode (RESET_INSTANT),
    .delay      (ioc_delay),
    .pickup     (residual_instant_overcurrent_pkp),
    .operate    (residual_instant_overcurrent_op)
  );

  // Each directional instance is a full, independent copy.
  for (genvar g = 0; g < DIR_COUNT; g++)
  begin : g_dir
    logic                     measured;  // Ground current operates.
    logic [K_W-1:0]           k_eff;     // Restraint after threshold.
    logic [K_W+MAG_W-1:0]     restr;     // K times I1, with fraction.
    logic [MAG_W-1:0]         restr_int;
    logic [MAG_W-1:0]         diff;
    logic [OP_W-1:0]          iop;       // Operating quantity.
    logic signed [MAG_W-1:0]  iref_re;   // Operating phasor.
    logic signed [MAG_W-1:0]  iref_im;
    logic signed [MAG_W-1:0]  zi_re;     // Current under the offset.
    logic signed [MAG_W-1:0]  zi_im;
    logic signed [MAG_W-1:0]  vp_re;     // Zero-sequence voltage used.
    logic signed [MAG_W-1:0]  vp_im;
    logic [MAG_W-1:0]         vp_mag;
    logic signed [2*MAG_W:0]  zp_re;     // Offset drop, with fraction.
    logic signed [2*MAG_W:0]  zp_im;
    logic signed [AX_W-1:0]   pol_re;    // -V0 plus the offset drop.
    logic signed [AX_W-1:0]   pol_im;
    logic                     v_fwd;
    logic                     v_rev;
    logic                     c_fwd;
    logic                     c_rev;
    logic                     v_ok;
    logic                     c_ok;
    pol_mode_type             mode_eff;
    logic                     fwd;
    logic                     rev;
    logic                     raw_fwd_q; // Direction latched per strobe.
    logic                     raw_rev_q;
    logic [OP_W-1:0]          iop_q;
    reversal_type             rev_state_q;
    logic [TCNT_W-1:0]        rev_cnt_q;
    logic                     fwd_op_q;
    logic                     rev_op_q;

    // Overcurrent unit: positive-sequence restraint only at high load.
    always_comb
    begin
      measured = (dir_op_source[g] == OP_MEASURED);
      if (i1_mag > I1_RESTRAIN_MIN)
        k_eff = dir_restraint_k[g];
      else
        k_eff = '0;
      restr = (K_W+MAG_W)'(k_eff) * (K_W+MAG_W)'(i1_mag);
      if (restr[K_W+MAG_W-1:K_FRAC] < (K_W+MAG_W-K_FRAC)'(i0_mag))
        restr_int = restr[K_FRAC+MAG_W-1:K_FRAC];
      else
        restr_int = i0_mag;
      diff = i0_mag - restr_int;
      if (measured)
        iop = OP_W'(ig_mag);
      else
        iop = OP_W'(diff) * GAIN_OP;
    end

    // Polarizing phasor; the offset impedance is a real scalar.
    always_comb
    begin
      if (measured)
      begin
        iref_re = ig_re;
        iref_im = ig_im;
        zi_re   = ig_re / DIV_S;
        zi_im   = ig_im / DIV_S;
      end
      else
      begin
        iref_re = i0_re;
        iref_im = i0_im;
        zi_re   = i0_re;
        zi_im   = i0_im;
      end
      if (polarizing_voltage_select[g] == VSEL_AUX)
      begin
        vp_re  = vx_re / DIV_S;
        vp_im  = vx_im / DIV_S;
        vp_mag = vx_mag / DIV_U;
      end
      else
      begin
        vp_re  = v0_re;
        vp_im  = v0_im;
        vp_mag = v0_mag;
      end
      zp_re  = (2*MAG_W+1)'($signed({1'b0, dir_offset_z[g]})) * zi_re;
      zp_im  = (2*MAG_W+1)'($signed({1'b0, dir_offset_z[g]})) * zi_im;
      pol_re = zp_re[Z_FRAC+AX_W-1:Z_FRAC] - AX_W'(vp_re);
      pol_im = zp_im[Z_FRAC+AX_W-1:Z_FRAC] - AX_W'(vp_im);
    end

    // Voltage comparator: polarizing phasor against rotated current.
    phasor_window_check u_vcmp (
      .a_re        (pol_re),
      .a_im        (pol_im),
      .b_re        (AX_W'(iref_re)),
      .b_im        (AX_W'(iref_im)),
      .rot_cos     (characteristic_angle_cos[g]),
      .rot_sin     (characteristic_angle_sin[g]),
      .fwd_lim_cos (forward_limit_cos[g]),
      .rev_lim_cos (reverse_limit_cos[g]),
      .fwd_hit     (v_fwd),
      .rev_hit     (v_rev)
    );

    // Current comparator: ground current against I0, angle fixed at 0.
    phasor_window_check u_icmp (
      .a_re        (AX_W'(ig_re)),
      .a_im        (AX_W'(ig_im)),
      .b_re        (AX_W'(i0_re)),
      .b_im        (AX_W'(i0_im)),
      .rot_cos     (ROT_UNITY),
      .rot_sin     (ROT_NONE),
      .fwd_lim_cos (forward_limit_cos[g]),
      .rev_lim_cos (reverse_limit_cos[g]),
      .fwd_hit     (c_fwd),
      .rev_hit     (c_rev)
    );

    // Direction decision; ground current cannot polarize itself, so the
    // measured mode always falls back to voltage polarizing.
    always_comb
    begin
      v_ok = vp_mag > VPOL_MIN;
      c_ok = ig_mag > IPOL_MIN;
      if (measured)
        mode_eff = POL_VOLTAGE;
      else
        mode_eff = dir_pol_mode[g];
      fwd = 1'b0;
      rev = 1'b0;
      unique case (mode_eff)
        POL_VOLTAGE:
        begin
          fwd = v_ok & v_fwd;
          rev = v_ok & v_rev;
        end
        POL_CURRENT:
        begin
          fwd = c_ok & c_fwd;
          rev = c_ok & c_rev;
        end
        POL_DUAL:
        begin
          fwd = (v_ok & v_fwd) | (c_ok & c_fwd);
          rev = ((v_ok & v_rev) | (c_ok & c_rev)) & ~fwd;
        end
        default:
        begin
          fwd = 1'b0;
          rev = 1'b0;
        end
      endcase
    end

    // Measurement results are sampled once per strobe.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        raw_fwd_q <= 1'b0;
        raw_rev_q <= 1'b0;
        iop_q     <= '0;
      end
      else if (meas_valid)
      begin
        raw_fwd_q <= fwd;
        raw_rev_q <= rev;
        iop_q     <= iop;
      end
    end

    // Current reversal guard: a long reverse arms it, and forward stays
    // held off for the delay after reverse drops. Counting runs on the
    // clock, not the strobe, so the timing is independent of the rate.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rev_state_q <= REV_IDLE;
        rev_cnt_q   <= '0;
      end
      else
      begin
        unique case (rev_state_q)
          REV_IDLE:
          begin
            if (!raw_rev_q)
              rev_cnt_q <= '0;
            else if (rev_cnt_q >= TCNT_W'(REV_PERSIST_CYCLES - 1))
              rev_state_q <= REV_ARMED;
            else
              rev_cnt_q <= rev_cnt_q + 1'b1;
          end
          REV_ARMED:
          begin
            if (!raw_rev_q)
            begin
              rev_state_q <= REV_HOLD;
              rev_cnt_q   <= TCNT_W'(FWD_DELAY_CYCLES - 1);
            end
          end
          REV_HOLD:
          begin
            if (raw_rev_q)
              rev_state_q <= REV_ARMED;
            else if (rev_cnt_q == '0)
              rev_state_q <= REV_IDLE;
            else
              rev_cnt_q <= rev_cnt_q - 1'b1;
          end
          default:
          begin
            rev_state_q <= REV_IDLE;
            rev_cnt_q   <= '0;
          end
        endcase
      end
    end

    // Operands need both the overcurrent and the directional unit.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        fwd_op_q <= 1'b0;
        rev_op_q <= 1'b0;
      end
      else
      begin
        fwd_op_q <= raw_fwd_q & (rev_state_q == REV_IDLE)
                    & (iop_q > dir_fwd_pickup[g]);
        rev_op_q <= raw_rev_q & (iop_q > dir_rev_pickup[g]);
      end
    end

    assign forward_direction_operand[g] = fwd_op_q;
    assign reverse_direction_operand[g] = rev_op_q;
  end

endmodule

// ===== src/phasor_window_check.sv
`timescale 1ns/1ps
module phasor_window_check
  import neutral_oc_pkg::*;
(
  input  wire logic signed [AX_W-1:0]  a_re,
  input  wire logic signed [AX_W-1:0]  a_im,
  input  wire logic signed [AX_W-1:0]  b_re,
  input  wire logic signed [AX_W-1:0]  b_im,
  input  wire logic signed [ROT_W-1:0] rot_cos,
  input  wire logic signed [ROT_W-1:0] rot_sin,
  input  wire logic        [LIM_W-1:0] fwd_lim_cos,
  input  wire logic        [LIM_W-1:0] rev_lim_cos,
  output logic                         fwd_hit,
  output logic                         rev_hit
);

  localparam int RT_W  = AX_W + ROT_W + 1;
  localparam int RR_W  = AX_W + ROT_W - ROT_FRAC;
  localparam int DOT_W = AX_W + RR_W + 1;

  logic signed [RT_W-1:0]  rt_re;  // Rotated reference, full width.
  logic signed [RT_W-1:0]  rt_im;
  logic signed [RR_W-1:0]  rr_re;  // Rotated reference, rescaled.
  logic signed [RR_W-1:0]  rr_im;
  logic signed [DOT_W-1:0] dot;    // Real part of a times conj(r).
  logic [SQ_W-1:0]         mag_a;
  logic [SQ_W-1:0]         mag_r;
  logic [SQ_W-1:0]         lhs;
  logic [SQ_W-1:0]         rhs_f;
  logic [SQ_W-1:0]         rhs_r;

  // The angle test avoids square roots and arctangents: the cosine of
  // the angle between a and r is compared through squares, which only
  // works for limit angles up to ninety degrees (cosine not negative).
  always_comb
  begin
    rt_re = RT_W'(b_re) * RT_W'(rot_cos) - RT_W'(b_im) * RT_W'(rot_sin);
    rt_im = RT_W'(b_re) * RT_W'(rot_sin) + RT_W'(b_im) * RT_W'(rot_cos);
    rr_re = rt_re[RT_W-2:ROT_FRAC];
    rr_im = rt_im[RT_W-2:ROT_FRAC];
    dot   = DOT_W'(a_re) * DOT_W'(rr_re) + DOT_W'(a_im) * DOT_W'(rr_im);
    mag_a = SQ_W'(a_re) * SQ_W'(a_re) + SQ_W'(a_im) * SQ_W'(a_im);
    mag_r = SQ_W'(rr_re) * SQ_W'(rr_re) + SQ_W'(rr_im) * SQ_W'(rr_im);
    lhs   = (SQ_W'(dot) * SQ_W'(dot)) << (2 * ROT_FRAC);
    rhs_f = SQ_W'(fwd_lim_cos) * SQ_W'(fwd_lim_cos) * mag_a * mag_r;
    rhs_r = SQ_W'(rev_lim_cos) * SQ_W'(rev_lim_cos) * mag_a * mag_r;
    // A zero phasor gives a zero product and never hits.
    fwd_hit = (dot > 0) && (lhs >= rhs_f);
    rev_hit = (dot < 0) && (lhs >= rhs_r);
  end

endmodule

// ===== src/pickup_timer.sv
`timescale 1ns/1ps
module pickup_timer
  import neutral_oc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               strobe,
  input  wire logic               above,
  input  wire logic               block,
  input  reset_mode_type          reset_mode,
  input  wire logic [TIMER_W-1:0] delay,
  output logic                    pickup,
  output logic                    operate
);

  logic [TIMER_W-1:0] acc_q;  // Time accumulator, in strobes.
  logic [TIMER_W-1:0] acc_d;
  logic               run;    // Above pickup and not blocked.

  // A blocked element resets exactly like one that dropped out.
  always_comb
  begin
    run   = above & ~block;
    acc_d = acc_q;
    if (run)
    begin
      if (acc_q < delay)
        acc_d = acc_q + 1'b1;
    end
    else if (reset_mode == RESET_INSTANT)
      acc_d = '0;
    else if (acc_q != '0)
      acc_d = acc_q - 1'b1;
  end

  // The accumulator moves only on a measurement strobe.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= '0;
    else if (strobe)
      acc_q <= acc_d;
  end

  // With a zero delay the element operates on the first strobe.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pickup  <= 1'b0;
      operate <= 1'b0;
    end
    else if (strobe)
    begin
      pickup  <= run;
      operate <= run & (acc_q >= delay);
    end
  end

endmodule
